// ### sycfg_consts.svh
// Purpose: constants for the system configuration readback block
// Assumes: 250 MHz core clock, serial frames of 16 bits, msb first
// Notes: included by the main module only
//
// Operation
// - address 10 with select 0 returns readback word; code replies with it on every frame and does not check select
// - read-only flag 1: reply, configuration kept
// - flag 0: reply old contents, then store
// - reserved bits 11, 10, 1 read zero
// - bit 9 picks ground shift threshold
// - bit 8 picks 20 ms or 1 ms reset
// - bits 7:6 pick aux supply mode
// - bit 5 picks reduced main undervoltage threshold
// - bit 4 picks current monitor action
// - bit 3 enables wake pin detection
// - bit 2 picks cyclic or continuous sampling
// - bit 0 drives inhibit pin high or floating
// - writes accepted only in normal or standby
// - reset state entry forces reset length to 1
// - fail-safe, reset pin fall, short clear aux
`ifndef SYCFG_CONSTS_SVH
`define SYCFG_CONSTS_SVH

`define SYCFG_FRAME_BITS 5'h10
`define SYCFG_CNT_MAX 5'h1F
`define SYCFG_ADDR_HI 15
`define SYCFG_ADDR_LO 14
`define SYCFG_ADDR_CFG 2'h2
`define SYCFG_TGT_SEL_BIT 13
`define SYCFG_RDONLY_BIT 12
`define SYCFG_GST_BIT 9
`define SYCFG_RSTLEN_BIT 8
`define SYCFG_AUX_HI 7
`define SYCFG_AUX_LO 6
`define SYCFG_UV_BIT 5
`define SYCFG_CM_BIT 4
`define SYCFG_WEN_BIT 3
`define SYCFG_WSAMP_BIT 2
`define SYCFG_INHIBIT_BIT 0
`define SYCFG_CFG_MASK 16'h03FD
`define SYCFG_CFG_RESET 16'h0100
`define SYCFG_AUX_OFF 2'h0
`define SYCFG_AUX_ON 2'h1
`define SYCFG_AUX_CYC16 2'h2
`define SYCFG_AUX_CYC32 2'h3
`define SYCFG_CLK_PERIOD_NS 4
`define SYCFG_AUX_ON_NS 350000
`define SYCFG_AUX_P16_NS 16000000
`define SYCFG_AUX_P32_NS 32000000

`endif

// ### sycfg_host_model.sv
// Purpose: host master model for the serial link
// Assumes: sclk idles low, data set on falling, reply sampled on rising
// Notes: sdi flips between frames, as an unselected line would
`timescale 1ns/1ps
module sycfg_host_model
(
    input wire logic clk,
    input wire logic sdo_w,
    output logic sclk,
    output logic scs_n,
    output logic sdi,
    output logic [15:0] rx,
    output logic done
);
    initial
    begin
        sclk = 1'b0;
        scs_n = 1'b1;
        sdi = 1'b0;
        rx = 16'h0000;
        done = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one frame of nb rising edges, msb first, half period hp clocks
    task automatic frame(input logic [15:0] w, input int nb, input int hp);
        @(negedge clk);
        rx = 16'h0000;
        scs_n = 1'b0;
        repeat (hp) @(negedge clk);
        for (int i = 15; i > 15 - nb; i--)
        begin
            sdi = w[i];
            repeat (hp) @(negedge clk);
            sclk = 1'b1;
            rx = {rx[14:0], sdo_w};
            repeat (hp) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (hp) @(negedge clk);
        scs_n = 1'b1;
        sdi = ~sdi;
        repeat (6) @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
    endtask
endmodule // sycfg_host_model

// ### sycfg_pkg.sv
// Purpose: types for the system configuration readback block
// Assumes: nothing beyond the constants header
// Notes: frame tracker state is one-hot
package sycfg_pkg;
    typedef enum logic [1:0] {
        SYCFG_ST_IDLE = 2'b01,
        SYCFG_ST_FRAME = 2'b10
    } sycfg_state_t;
endpackage

// ### sycfg_readback.sv
// Purpose: serial access, storage and readback of the system configuration
// Assumes: serial clock idles low, sampled on rising, shifted on falling
// Notes: fail-safe events win over a concurrent serial write
`timescale 1ns/1ps
`include "sycfg_consts.svh"
module sycfg_readback
    import sycfg_pkg::*;
#(
    parameter int AUX_ON_CYC = `SYCFG_AUX_ON_NS / `SYCFG_CLK_PERIOD_NS,
    parameter int AUX_P16_CYC = `SYCFG_AUX_P16_NS / `SYCFG_CLK_PERIOD_NS,
    parameter int AUX_P32_CYC = `SYCFG_AUX_P32_NS / `SYCFG_CLK_PERIOD_NS,
    parameter int AUX_CNT_W = 23
)
(
    input wire logic clk,
    input wire logic external_reset_pin,
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic mode_write_ok,
    input wire logic enter_reset_state,
    input wire logic enter_failsafe,
    input wire logic external_reset_pin_n,
    input wire logic aux_short_detect,
    output logic ground_shift_level_sel,
    output logic reset_pulse_length_sel,
    output logic [1:0] aux_supply_control,
    output logic aux_supply_on,
    output logic main_undervoltage_level_sel,
    output logic main_current_monitor_sel,
    output logic wake_enable,
    output logic wake_sampling_select,
    output logic host_supply_switch_pin,
    output logic host_supply_switch_pin_oe
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edges
    logic [3:0] pins_s;
    logic sclk_s, scs_n_s, sdi_s, xrst_n_s;
    logic sclk_p_q, scs_n_p_q, xrst_n_p_q;
    logic sclk_rise, sclk_fall, frame_start, frame_end, xrst_fall;

    sycfg_sync #(.W(4), .INIT(4'hA)) u_sync (
        .clk(clk),
        .external_reset_pin(external_reset_pin),
        .din({external_reset_pin_n, sdi, scs_n, sclk}),
        .dout(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign scs_n_s = pins_s[1];
    assign sdi_s = pins_s[2];
    assign xrst_n_s = pins_s[3];

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
        begin
            sclk_p_q <= 1'b0;
            scs_n_p_q <= 1'b1;
            xrst_n_p_q <= 1'b1;
        end
        else
        begin
            sclk_p_q <= sclk_s;
            scs_n_p_q <= scs_n_s;
            xrst_n_p_q <= xrst_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_p_q;
    assign sclk_fall = ~sclk_s & sclk_p_q;
    assign frame_start = ~scs_n_s & scs_n_p_q;
    assign frame_end = scs_n_s & ~scs_n_p_q;
    assign xrst_fall = ~xrst_n_s & xrst_n_p_q;

    ////////////////////////////////////////////////////////////////////////
    // readback word
    logic [15:0] cfg_q, cfg_d;

    function automatic logic [15:0] sycfg_word(input logic [15:0] cfg);
        logic [15:0] w;
        w = cfg & `SYCFG_CFG_MASK;
        w[`SYCFG_ADDR_HI:`SYCFG_ADDR_LO] = `SYCFG_ADDR_CFG;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // frame tracking and shifting
    sycfg_state_t state_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] rx_q, tx_q;
    logic commit, write_ok;

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
            state_q <= SYCFG_ST_IDLE;
        else
        begin
            unique case (state_q)
                SYCFG_ST_IDLE: if (frame_start) state_q <= SYCFG_ST_FRAME;
                SYCFG_ST_FRAME: if (frame_end) state_q <= SYCFG_ST_IDLE;
                default: state_q <= SYCFG_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
        begin
            bit_cnt_q <= 5'h0;
            rx_q <= 16'h0;
        end
        else if (frame_start)
            bit_cnt_q <= 5'h0;
        else if (state_q == SYCFG_ST_FRAME && sclk_rise)
        begin
            rx_q <= {rx_q[14:0], sdi_s};
            if (bit_cnt_q != `SYCFG_CNT_MAX)
                bit_cnt_q <= bit_cnt_q + 5'h1;
        end
    end

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
            tx_q <= 16'h0;
        else if (frame_start)
            tx_q <= sycfg_word(cfg_q);
        else if (state_q == SYCFG_ST_FRAME && sclk_fall)
            tx_q <= {tx_q[14:0], 1'b0};
    end

    assign sdo = tx_q[15];
    assign sdo_oe = (state_q == SYCFG_ST_FRAME);

    assign commit = (state_q == SYCFG_ST_FRAME) && frame_end && (bit_cnt_q == `SYCFG_FRAME_BITS)
        && (rx_q[`SYCFG_ADDR_HI:`SYCFG_ADDR_LO] == `SYCFG_ADDR_CFG);
    assign write_ok = commit && !rx_q[`SYCFG_RDONLY_BIT] && mode_write_ok;

    ////////////////////////////////////////////////////////////////////////
    // configuration storage
    always_comb
    begin
        cfg_d = cfg_q;
        if (write_ok)
            cfg_d = rx_q & `SYCFG_CFG_MASK;
        if (enter_reset_state)
            cfg_d[`SYCFG_RSTLEN_BIT] = 1'b1;
        if (enter_failsafe || xrst_fall || aux_short_detect)
            cfg_d[`SYCFG_AUX_HI:`SYCFG_AUX_LO] = `SYCFG_AUX_OFF;
    end

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
            cfg_q <= `SYCFG_CFG_RESET;
        else
            cfg_q <= cfg_d;
    end

    assign ground_shift_level_sel = cfg_q[`SYCFG_GST_BIT];
    assign reset_pulse_length_sel = cfg_q[`SYCFG_RSTLEN_BIT];
    assign aux_supply_control = cfg_q[`SYCFG_AUX_HI:`SYCFG_AUX_LO];
    assign main_undervoltage_level_sel = cfg_q[`SYCFG_UV_BIT];
    assign main_current_monitor_sel = cfg_q[`SYCFG_CM_BIT];
    assign wake_enable = cfg_q[`SYCFG_WEN_BIT];
    assign wake_sampling_select = cfg_q[`SYCFG_WSAMP_BIT];
    assign host_supply_switch_pin = 1'b1;
    assign host_supply_switch_pin_oe = cfg_q[`SYCFG_INHIBIT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // aux supply on/off timing
    logic [AUX_CNT_W-1:0] aux_cnt_q, aux_period;

    assign aux_period = (aux_supply_control == `SYCFG_AUX_CYC32) ? AUX_CNT_W'(AUX_P32_CYC)
        : AUX_CNT_W'(AUX_P16_CYC);

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
            aux_cnt_q <= '0;
        else if (!aux_supply_control[1] || aux_cnt_q >= aux_period - AUX_CNT_W'(1))
            aux_cnt_q <= '0;
        else
            aux_cnt_q <= aux_cnt_q + AUX_CNT_W'(1);
    end

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
            aux_supply_on <= 1'b0;
        else
        begin
            unique case (aux_supply_control)
                `SYCFG_AUX_OFF: aux_supply_on <= 1'b0;
                `SYCFG_AUX_ON: aux_supply_on <= 1'b1;
                default: aux_supply_on <= (aux_cnt_q < AUX_CNT_W'(AUX_ON_CYC));
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!external_reset_pin);

    a_rdonly_keeps_cfg: assert property (
        commit && rx_q[`SYCFG_RDONLY_BIT] && !enter_reset_state && !enter_failsafe && !xrst_fall && !aux_short_detect
        |=> cfg_q == $past(cfg_q))
        else $error("read-only frame changed configuration");
    a_write_stores: assert property (
        write_ok && !enter_reset_state && !enter_failsafe && !xrst_fall && !aux_short_detect
        |=> cfg_q == ($past(rx_q) & `SYCFG_CFG_MASK))
        else $error("write frame not stored");
    a_mode_gate: assert property (
        commit && !mode_write_ok && !enter_reset_state && !enter_failsafe && !xrst_fall && !aux_short_detect
        |=> $stable(cfg_q))
        else $error("write accepted outside allowed modes");
    a_rstlen_forced: assert property (
        enter_reset_state |=> reset_pulse_length_sel)
        else $error("reset length not forced");
    a_aux_cleared: assert property (
        enter_failsafe || xrst_fall || aux_short_detect |=> aux_supply_control == `SYCFG_AUX_OFF)
        else $error("aux control not cleared");
    a_first_bit: assert property (
        frame_start |=> sdo_oe && sdo && !tx_q[14] && !tx_q[13])
        else $error("reply does not open with address 10");
    a_old_reflect: assert property (
        frame_start |=> tx_q[9:0] == ($past(cfg_q[9:0]) & 10'h3FD))
        else $error("reply does not show stored contents");
    a_reserved_zero: assert property (
        cfg_q[11] == 1'b0 && cfg_q[10] == 1'b0 && cfg_q[1] == 1'b0)
        else $error("reserved bit set");
    a_inhibit_drive: assert property (
        host_supply_switch_pin_oe == cfg_q[`SYCFG_INHIBIT_BIT] && host_supply_switch_pin)
        else $error("inhibit pin drive wrong");
    a_aux_off: assert property (
        aux_supply_control == `SYCFG_AUX_OFF [*2] |-> !aux_supply_on)
        else $error("aux supply on while off");
endmodule // sycfg_readback

// ### sycfg_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
module sycfg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic external_reset_pin,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge external_reset_pin)
    begin
        if (!external_reset_pin)
        begin
            meta_q <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // sycfg_sync

// ### test_system_config_readback.sv
// Purpose: self-checking bench for the configuration readback block
// Assumes: shortened aux supply timing, link half period 20 or 4 clocks
// Notes: every frame checks the reply word and the settings outputs
`timescale 1ns/1ps
module test_system_config_readback;
    logic clk, external_reset_pin, sclk, scs_n, sdi, sdo, sdo_oe, done, aux_done;
    logic mode_write_ok, enter_reset_state, enter_failsafe, external_reset_pin_n, aux_short_detect;
    logic gsl, rpl, aux_on, uv, cm, wen, wsamp, inhib_oe, inhib_pin;
    logic [1:0] aux;
    logic [15:0] cfg, rx;
    logic [31:0] seed, e, g;
    logic [31:0] q[$];
    int bad_count, checked, cnt;
    int exps[4] = '{0, 96, 24, 12};
    int evs[4] = '{4, 2, 1, 8};
    wire logic sdo_w = sdo_oe ? sdo : ~sdo;
    wire logic [15:0] cfgv = {6'h00, gsl, rpl, aux, uv, cm, wen, wsamp, 1'b0, inhib_oe & inhib_pin};
    sycfg_readback #(.AUX_ON_CYC(4), .AUX_P16_CYC(16), .AUX_P32_CYC(32)) u_sycfg_readback (.clk(clk), .external_reset_pin(external_reset_pin),
        .sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .mode_write_ok(mode_write_ok),
        .enter_reset_state(enter_reset_state), .enter_failsafe(enter_failsafe),
        .external_reset_pin_n(external_reset_pin_n), .aux_short_detect(aux_short_detect),
        .ground_shift_level_sel(gsl), .reset_pulse_length_sel(rpl), .aux_supply_control(aux),
        .aux_supply_on(aux_on), .main_undervoltage_level_sel(uv), .main_current_monitor_sel(cm),
        .wake_enable(wen), .wake_sampling_select(wsamp), .host_supply_switch_pin(inhib_pin),
        .host_supply_switch_pin_oe(inhib_oe));
    sycfg_host_model u_sycfg_host_model (.clk(clk), .sdo_w(sdo_w), .sclk(sclk), .scs_n(scs_n), .sdi(sdi),
        .rx(rx), .done(done));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic xfer(input logic [15:0] w, input int nb, input int hp);
        logic [15:0] rep;
        rep = 16'h8000 | cfg;
        if (nb == 16 && w[15:14] == 2'h2 && !w[12] && mode_write_ok)
            cfg = w & 16'h03FD;
        q.push_back({rep >> (16 - nb), cfg});
        u_sycfg_host_model.frame(w, nb, hp);
    endtask
    task automatic aux_run(input logic [1:0] m, input int ex);
        xfer({8'h80, m, 6'h00}, 16, 4);
        cnt = 0;
        repeat (96)
        begin
            @(negedge clk);
            cnt += aux_on;
        end
        q.push_back({16'h0000, ex[15:0]});
        aux_done = 1'b1;
        @(negedge clk);
        aux_done = 1'b0;
    endtask
    task automatic side_ev(input int k);
        xfer(16'h80C0, 16, 4);
        {enter_reset_state, enter_failsafe, aux_short_detect} = k[2:0];
        external_reset_pin_n = ~k[3];
        @(negedge clk);
        {enter_reset_state, enter_failsafe, aux_short_detect} = 3'b000;
        external_reset_pin_n = 1'b1;
        repeat (5) @(negedge clk);
        if (k[2])
            cfg[8] = 1'b1;
        else
            cfg[7:6] = 2'b00;
        xfer(16'h9000, 16, 4);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (done || aux_done)
        begin
            e = q.pop_front();
            g = done ? {rx, cfgv} : {16'h0000, cnt[15:0]};
            checked++;
            if (g !== e)
            begin
                bad_count++;
                $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #300000;
        bad_count++;
        close_out();
    end
    initial
    begin
        {external_reset_pin, enter_reset_state, enter_failsafe, aux_short_detect, aux_done} = 5'h00;
        mode_write_ok = 1'b1;
        external_reset_pin_n = 1'b1;
        cfg = 16'h0100;
        seed = 32'h006D;
        repeat (10) @(negedge clk);
        external_reset_pin = 1'b1;
        repeat (3) @(negedge clk);
        xfer(16'h9000, 16, 20);
        repeat (6)
        begin
            seed = xs(seed);
            xfer(16'h8000 | (seed[15:0] & 16'h03FD), 16, seed[16] ? 4 : 20);
        end
        xfer(16'h83FD, 16, 20);
        xfer(16'h9000, 16, 4);
        xfer(16'h8000, 15, 20);
        xfer(16'hA000, 16, 20);
        xfer(16'h4000, 16, 20);
        mode_write_ok = 1'b0;
        xfer(16'h8000, 16, 4);
        mode_write_ok = 1'b1;
        xfer(16'h9000, 16, 4);
        foreach (evs[i])
            side_ev(evs[i]);
        for (int m = 3; m >= 0; m--)
            aux_run(m[1:0], exps[m]);
        repeat (4) @(negedge clk);
        close_out();
    end
endmodule // test_system_config_readback
